// File: ccts_pkg.sv
// Constants for the machine-cycle sequencer and lower special register map.
// Assumes an 8-bit direct-address register port and one oscillator clock.
package ccts_pkg;

  // Timing in oscillator clocks and machine cycles
  localparam int CLKS_PER_MCYCLE = 4;
  localparam int CLKS_PER_LEGACY_TICK = 12;
  localparam int XMOVE_MCYCLES = 2;
  localparam int DDMOVE_MCYCLES = 3;
  localparam int MIN_MCYCLES = 1;
  localparam int MAX_MCYCLES = 5;

  // Register addresses
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] SFR_LAST = 8'hA4;
  localparam logic [7:0] ADR_PORT4_LATCH = 8'h80;
  localparam logic [7:0] ADR_STACK_POINTER_LOW = 8'h81;
  localparam logic [7:0] ADR_POINTER0_LOW = 8'h82;
  localparam logic [7:0] ADR_POINTER0_HIGH = 8'h83;
  localparam logic [7:0] ADR_POINTER1_LOW = 8'h84;
  localparam logic [7:0] ADR_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] ADR_POINTER_SELECT = 8'h86;
  localparam logic [7:0] ADR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADR_TIMER0_COUNT_LOW = 8'h8A;
  localparam logic [7:0] ADR_TIMER1_COUNT_LOW = 8'h8B;
  localparam logic [7:0] ADR_TIMER0_COUNT_HIGH = 8'h8C;
  localparam logic [7:0] ADR_TIMER1_COUNT_HIGH = 8'h8D;
  localparam logic [7:0] ADR_CLOCK_CONTROL = 8'h8E;
  localparam logic [7:0] ADR_PORT1_LATCH = 8'h90;
  localparam logic [7:0] ADR_EXTENDED_INTERRUPT_FLAGS = 8'h91;
  localparam logic [7:0] ADR_PORT4_FUNCTION_CONTROL = 8'h92;
  localparam logic [7:0] ADR_POINTER0_EXTENSION = 8'h93;
  localparam logic [7:0] ADR_POINTER1_EXTENSION = 8'h95;
  localparam logic [7:0] ADR_CAN0_RX_MSG_STORE0 = 8'h96;
  localparam logic [7:0] ADR_CAN0_RX_MSG_STORE1 = 8'h97;
  localparam logic [7:0] ADR_SERIAL0_CONTROL = 8'h98;
  localparam logic [7:0] ADR_SERIAL0_BUFFER = 8'h99;
  localparam logic [7:0] ADR_STACK_POINTER_EXTENSION = 8'h9B;
  localparam logic [7:0] ADR_ADDRESS_PAGE = 8'h9C;
  localparam logic [7:0] ADR_ADDRESS_MODE_CONTROL = 8'h9D;
  localparam logic [7:0] ADR_CAN0_TX_MSG_ACK0 = 8'h9E;
  localparam logic [7:0] ADR_CAN0_TX_MSG_ACK1 = 8'h9F;
  localparam logic [7:0] ADR_PORT2_LATCH = 8'hA0;
  localparam logic [7:0] ADR_PORT5_LATCH = 8'hA1;
  localparam logic [7:0] ADR_PORT5_FUNCTION_CONTROL = 8'hA2;
  localparam logic [7:0] ADR_CAN0_CONTROL = 8'hA3;
  localparam logic [7:0] ADR_CAN0_STATUS = 8'hA4;

  // Reset values
  localparam logic [7:0] RST_PORT = 8'hFF;
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Clock control fields
  localparam int CKC_TIMER0_FAST = 3;
  localparam int CKC_TIMER1_FAST = 4;
  localparam int CKC_TIMER2_FAST = 5;

  // Timer control fields
  localparam int TC_TF1 = 7;
  localparam int TC_TR1 = 6;
  localparam int TC_TF0 = 5;
  localparam int TC_TR0 = 4;

  // Timer mode fields, timer 1 in the upper nibble
  localparam int TM_T1_LSB = 4;
  localparam int TM_GATE = 3;
  localparam int TM_CT = 2;

  typedef enum logic [1:0] {CCTS_GENERIC, CCTS_XMOVE, CCTS_DDMOVE, CCTS_LONG} ccts_class_t;

endpackage

// File: ccts_core.sv
// Machine-cycle sequencer, legacy/fast timer prescale and the 80h..A4h register map.
// Assumes the core supplies instruction class and byte count; the register port
// is the direct-address path driven by the execution unit, one access per clock.
//
// How it works
// - Every machine cycle is exactly four oscillator clocks, no dummy cycles.
// - After reset timers advance once per twelve oscillator clocks.
// - Software may make each timer advance once per four clocks instead.
// - One address latch strobe pulse is given in every machine cycle.
// - External data move through the pointer completes in two machine cycles.
// - Direct-to-direct move takes three machine cycles, twelve clocks.
// - Generally one machine cycle per opcode or operand byte fetched.
// - Instructions last from one up to five machine cycles.
// - Flags and status update exactly as the original architecture; only timing differs.
// - Added registers sit at addresses distinct from standard register locations.
`timescale 1ns/10ps

module ccts_core
  import ccts_pkg::*;
#(
  parameter int MCYCLE_CLOCKS = CLKS_PER_MCYCLE,
  parameter int LEGACY_CLOCKS = CLKS_PER_LEGACY_TICK
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_instr_start,
  input wire ccts_class_t i_instr_class,
  input wire logic [2:0] i_instr_bytes,
  output logic o_instr_ready,
  output logic o_instr_done,
  output logic [2:0] o_mcycle_index,
  output logic o_ale,
  output logic o_mcycle_end,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_t0_pin,
  input wire logic i_t1_pin,
  input wire logic i_int0_n,
  input wire logic i_int1_n,
  input wire logic i_tf0_ack,
  input wire logic i_tf1_ack,
  output logic o_tf0,
  output logic o_tf1,
  output logic [2:0] o_timer_fast
);

  if (MCYCLE_CLOCKS != 4 || LEGACY_CLOCKS < MCYCLE_CLOCKS || LEGACY_CLOCKS > 255) begin : g_bad_clocks
    $error("ccts_core: unsupported cycle clock counts");
  end

  localparam int NREG = 37;
  localparam logic [1:0] PH_LAST = 2'(MCYCLE_CLOCKS - 1);
  localparam logic [7:0] LEG_LAST = 8'(LEGACY_CLOCKS - 1);

  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_RUN} ccts_seq_t;

  // Cycles an instruction needs, bounded to the legal range
  function automatic logic [2:0] ccts_cycles(input ccts_class_t cls, input logic [2:0] nbytes);
    logic [2:0] n;
    n = nbytes;
    unique case (cls)
      CCTS_XMOVE: n = 3'(XMOVE_MCYCLES);
      CCTS_DDMOVE: n = 3'(DDMOVE_MCYCLES);
      CCTS_LONG: n = 3'(MAX_MCYCLES);
      CCTS_GENERIC: n = nbytes;
    endcase
    if (n < 3'(MIN_MCYCLES)) begin
      n = 3'(MIN_MCYCLES);
    end
    if (n > 3'(MAX_MCYCLES)) begin
      n = 3'(MAX_MCYCLES);
    end
    return n;
  endfunction

  // Address held by a register of this map
  function automatic logic ccts_mapped(input logic [7:0] a);
    return (a >= SFR_BASE) && (a <= SFR_LAST) && (a != 8'h8F) && (a != 8'h94) && (a != 8'h9A);
  endfunction

  // Counter step for one timer: {overflow, high, low}
  function automatic logic [16:0] ccts_step(input logic [1:0] mode, input logic [7:0] th, input logic [7:0] tl);
    logic [16:0] r;
    logic [13:0] m0;
    logic [16:0] m1;
    logic [8:0] m2;
    m0 = {1'b0, th, tl[4:0]} + 14'h0001;
    m1 = {1'b0, th, tl} + 17'h00001;
    m2 = {1'b0, tl} + 9'h001;
    r = {1'b0, th, tl};
    unique case (mode)
      2'h0: r = {m0[13], m0[12:5], tl[7:5], m0[4:0]};
      2'h1: r = m1;
      2'h2: r = {m2[8], th, (m2[8] ? th : m2[7:0])};
      2'h3: r = {m2[8], th, m2[7:0]};
    endcase
    return r;
  endfunction

  // Machine cycle phase
  logic [1:0] phase_q;
  logic cyc_end;
  assign cyc_end = (phase_q == PH_LAST);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= cyc_end ? 2'h0 : phase_q + 2'h1;
    end
  end

  logic ale_q;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ale_q <= 1'b0;
    end else begin
      ale_q <= cyc_end;
    end
  end
  assign o_ale = ale_q;
  assign o_mcycle_end = cyc_end;

  // Instruction sequencer
  ccts_seq_t seq_q;
  logic [2:0] need_q;
  logic [2:0] idx_q;
  logic done_q;
  assign o_instr_ready = (seq_q == SQ_IDLE);
  assign o_instr_done = done_q;
  assign o_mcycle_index = idx_q;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seq_q <= SQ_IDLE;
      need_q <= 3'h1;
      idx_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (seq_q)
        SQ_IDLE: begin
          if (i_instr_start) begin
            need_q <= ccts_cycles(i_instr_class, i_instr_bytes);
            idx_q <= 3'h0;
            seq_q <= cyc_end ? SQ_RUN : SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          if (cyc_end) begin
            seq_q <= SQ_RUN;
          end
        end
        SQ_RUN: begin
          if (cyc_end) begin
            if (idx_q + 3'h1 == need_q) begin
              done_q <= 1'b1;
              idx_q <= 3'h0;
              seq_q <= SQ_IDLE;
            end else begin
              idx_q <= idx_q + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // Legacy twelve-clock tick
  logic [7:0] leg_q;
  logic leg_tick;
  assign leg_tick = (leg_q == LEG_LAST);
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      leg_q <= 8'h00;
    end else begin
      leg_q <= leg_tick ? 8'h00 : leg_q + 8'h01;
    end
  end

  // Timer registers
  logic [7:0] timer_control_q;
  logic [7:0] timer_mode_q;
  logic [7:0] clock_control_q;
  logic [7:0] tl0_q;
  logic [7:0] th0_q;
  logic [7:0] tl1_q;
  logic [7:0] th1_q;
  logic wr;
  assign wr = i_sfr_wr && ccts_mapped(i_sfr_addr);

  logic tick0;
  logic tick1;
  assign tick0 = clock_control_q[CKC_TIMER0_FAST] ? cyc_end : leg_tick;
  assign tick1 = clock_control_q[CKC_TIMER1_FAST] ? cyc_end : leg_tick;
  assign o_timer_fast = clock_control_q[CKC_TIMER2_FAST:CKC_TIMER0_FAST];

  // Counter inputs seen once per machine cycle
  logic t0_prev_q;
  logic t1_prev_q;
  logic t0_fall;
  logic t1_fall;
  assign t0_fall = t0_prev_q && !i_t0_pin;
  assign t1_fall = t1_prev_q && !i_t1_pin;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      t0_prev_q <= 1'b1;
      t1_prev_q <= 1'b1;
    end else if (cyc_end) begin
      t0_prev_q <= i_t0_pin;
      t1_prev_q <= i_t1_pin;
    end
  end

  logic [3:0] m0f;
  logic [3:0] m1f;
  logic run0;
  logic run1;
  logic inc0;
  logic inc1;
  logic inc0h;
  logic [16:0] s0;
  logic [16:0] s1;
  logic [8:0] s0h;
  assign m0f = timer_mode_q[TM_T1_LSB-1:0];
  assign m1f = timer_mode_q[7:TM_T1_LSB];
  assign run0 = timer_control_q[TC_TR0] && (!m0f[TM_GATE] || i_int0_n);
  assign run1 = timer_control_q[TC_TR1] && (!m1f[TM_GATE] || i_int1_n) && (m1f[1:0] != 2'h3);
  assign inc0 = run0 && (m0f[TM_CT] ? (cyc_end && t0_fall) : tick0);
  assign inc1 = run1 && (m1f[TM_CT] ? (cyc_end && t1_fall) : tick1);
  // Split timer 0: high half runs off timer 1's run bit
  assign inc0h = (m0f[1:0] == 2'h3) && timer_control_q[TC_TR1] && tick0;
  assign s0 = ccts_step(m0f[1:0], th0_q, tl0_q);
  assign s1 = ccts_step(m1f[1:0], th1_q, tl1_q);
  assign s0h = {1'b0, th0_q} + 9'h001;

  logic ovf0;
  logic ovf1;
  assign ovf0 = inc0 && s0[16];
  assign ovf1 = (m0f[1:0] == 2'h3) ? (inc0h && s0h[8]) : (inc1 && s1[16]);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tl0_q <= RST_ZERO;
      th0_q <= RST_ZERO;
    end else begin
      if (wr && i_sfr_addr == ADR_TIMER0_COUNT_LOW) begin
        tl0_q <= i_sfr_wdata;
      end else if (inc0) begin
        tl0_q <= s0[7:0];
      end
      if (wr && i_sfr_addr == ADR_TIMER0_COUNT_HIGH) begin
        th0_q <= i_sfr_wdata;
      end else if (inc0h) begin
        th0_q <= s0h[7:0];
      end else if (inc0 && m0f[1:0] != 2'h3) begin
        th0_q <= s0[15:8];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tl1_q <= RST_ZERO;
      th1_q <= RST_ZERO;
    end else begin
      if (wr && i_sfr_addr == ADR_TIMER1_COUNT_LOW) begin
        tl1_q <= i_sfr_wdata;
      end else if (inc1) begin
        tl1_q <= s1[7:0];
      end
      if (wr && i_sfr_addr == ADR_TIMER1_COUNT_HIGH) begin
        th1_q <= i_sfr_wdata;
      end else if (inc1) begin
        th1_q <= s1[15:8];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_control_q <= RST_ZERO;
    end else begin
      if (wr && i_sfr_addr == ADR_TIMER_CONTROL) begin
        timer_control_q <= i_sfr_wdata;
      end
      if (ovf0) begin
        timer_control_q[TC_TF0] <= 1'b1;
      end else if (i_tf0_ack) begin
        timer_control_q[TC_TF0] <= 1'b0;
      end else if (wr && i_sfr_addr == ADR_TIMER_CONTROL) begin
        timer_control_q[TC_TF0] <= i_sfr_wdata[TC_TF0];
      end
      if (ovf1) begin
        timer_control_q[TC_TF1] <= 1'b1;
      end else if (i_tf1_ack) begin
        timer_control_q[TC_TF1] <= 1'b0;
      end else if (wr && i_sfr_addr == ADR_TIMER_CONTROL) begin
        timer_control_q[TC_TF1] <= i_sfr_wdata[TC_TF1];
      end
    end
  end
  assign o_tf0 = timer_control_q[TC_TF0];
  assign o_tf1 = timer_control_q[TC_TF1];

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_mode_q <= RST_ZERO;
      clock_control_q <= RST_ZERO;
    end else if (wr) begin
      if (i_sfr_addr == ADR_TIMER_MODE) begin
        timer_mode_q <= i_sfr_wdata;
      end
      if (i_sfr_addr == ADR_CLOCK_CONTROL) begin
        clock_control_q <= i_sfr_wdata;
      end
    end
  end

  // Plain storage for the remaining registers of the map
  logic [7:0] regs_q [NREG];
  logic [5:0] widx;
  assign widx = 6'(i_sfr_addr - SFR_BASE);

  function automatic logic [7:0] ccts_reset_value(input int i);
    logic [7:0] a;
    a = 8'(i) + SFR_BASE;
    if (a == ADR_PORT4_LATCH || a == ADR_PORT1_LATCH || a == ADR_PORT2_LATCH || a == ADR_PORT5_LATCH) begin
      return RST_PORT;
    end
    if (a == ADR_STACK_POINTER_LOW) begin
      return RST_STACK_POINTER;
    end
    return RST_ZERO;
  endfunction

  function automatic logic ccts_read_only(input logic [7:0] a);
    return a == ADR_CAN0_RX_MSG_STORE0 || a == ADR_CAN0_RX_MSG_STORE1 ||
           a == ADR_CAN0_TX_MSG_ACK0 || a == ADR_CAN0_TX_MSG_ACK1;
  endfunction

  // added registers decoded at their own addresses only
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= ccts_reset_value(i);
      end
    end else if (wr && !ccts_read_only(i_sfr_addr)) begin
      regs_q[widx] <= i_sfr_wdata;
    end
  end

  // Read port, data one clock after the request
  logic [7:0] rdata_q;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= RST_ZERO;
    end else if (i_sfr_rd) begin
      if (!ccts_mapped(i_sfr_addr)) begin
        rdata_q <= RST_ZERO;
      end else begin
        unique case (i_sfr_addr)
          ADR_TIMER_CONTROL: rdata_q <= timer_control_q;
          ADR_TIMER_MODE: rdata_q <= timer_mode_q;
          ADR_CLOCK_CONTROL: rdata_q <= clock_control_q;
          ADR_TIMER0_COUNT_LOW: rdata_q <= tl0_q;
          ADR_TIMER0_COUNT_HIGH: rdata_q <= th0_q;
          ADR_TIMER1_COUNT_LOW: rdata_q <= tl1_q;
          ADR_TIMER1_COUNT_HIGH: rdata_q <= th1_q;
          default: rdata_q <= regs_q[widx];
        endcase
      end
    end
  end
  assign o_sfr_rdata = rdata_q;

endmodule

// File: ccts_core_assertions.sv
// Checker for the machine-cycle sequencer and register port of ccts_core.
// Assumes it is bound onto ccts_core; one clock, active-low reset.
`timescale 1ns/10ps
module ccts_core_assertions
  import ccts_pkg::*;
#(
  parameter int MCYCLE_CLOCKS = 4,
  parameter int LEGACY_CLOCKS = 12
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_instr_start,
  input wire ccts_class_t i_instr_class,
  input wire logic [2:0] i_instr_bytes,
  input wire logic o_instr_ready,
  input wire logic o_instr_done,
  input wire logic o_ale,
  input wire logic o_mcycle_end,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic [2:0] o_timer_fast
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  // Request taken in phase 3, so the run starts at the next phase 0
  wire logic take = i_instr_start && o_instr_ready && o_mcycle_end;
  wire logic gap = i_sfr_addr < 8'h80 || i_sfr_addr > 8'hA4 || i_sfr_addr inside {8'h8F, 8'h94, 8'h9A};
  wire logic [2:0] wsel = i_sfr_wdata[CKC_TIMER2_FAST:CKC_TIMER0_FAST];
  a_ale_period: assert property (o_ale |=> !o_ale [*3] ##1 o_ale)
    else $error("strobe spacing not four clocks");
  a_end_then_ale: assert property (o_mcycle_end |=> o_ale)
    else $error("no strobe after cycle end");
  a_done_on_end: assert property (o_instr_done |-> $past(o_mcycle_end))
    else $error("done not right after a cycle end");
  a_xmove_cycles: assert property (take && i_instr_class == CCTS_XMOVE |=> !o_instr_done [*8] ##1 o_instr_done)
    else $error("external move not eight clocks");
  a_ddmove_cycles: assert property (take && i_instr_class == CCTS_DDMOVE |-> ##13 o_instr_done)
    else $error("direct move not twelve clocks");
  a_long_cycles: assert property (take && i_instr_class == CCTS_LONG |-> ##21 o_instr_done)
    else $error("long instruction not five cycles");
  a_one_byte: assert property (take && i_instr_class == CCTS_GENERIC && i_instr_bytes == 3'h1 |-> ##5 o_instr_done)
    else $error("one-byte instruction not one cycle");
  a_ready_busy: assert property (i_instr_start && o_instr_ready |=> !o_instr_ready)
    else $error("ready stayed high after a take");
  a_fast_select: assert property (i_sfr_wr && i_sfr_addr == ADR_CLOCK_CONTROL |=> o_timer_fast == $past(wsel))
    else $error("speed bits not taken from write");
  a_gap_reads_zero: assert property (i_sfr_rd && gap |=> o_sfr_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  c_xmove: cover property (take && i_instr_class == CCTS_XMOVE);
  c_fast: cover property (o_timer_fast[0]);
  c_gap: cover property (i_sfr_rd && i_sfr_addr == 8'h94);
endmodule

// File: ccts_mem_model.sv
// External memory stand-in: counts the address latch strobes it sees.
// Assumes the strobe is sampled on the oscillator clock.
`timescale 1ns/10ps
module ccts_mem_model (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_ale,
  output int o_latch_count
);
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_latch_count <= 0;
    end else if (i_ale) begin
      o_latch_count <= o_latch_count + 1;
    end
  end
endmodule

// File: ccts_core_test.sv
// Self-checking bench for the cycle sequencer and lower register map.
// Assumes ccts_pkg, the checker and the memory model are compiled first.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module ccts_core_test;
  import ccts_pkg::*;
  logic i_core_clk = 0, i_reset_n = 0, start = 0, wr = 0, rd = 0, pin = 1, ack = 0;
  ccts_class_t cls = CCTS_GENERIC;
  logic [2:0] nbytes = 3'h1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, v;
  wire logic ready, done, ale, mend, tf0, tf1;
  wire logic [2:0] idx, fast;
  wire logic [7:0] rdata;
  int mismatches = 0, checks = 0, cyc = 0, ale_cnt;
  int mdl [256];
  ccts_class_t cq[$] = '{CCTS_GENERIC, CCTS_XMOVE, CCTS_DDMOVE, CCTS_LONG};
  ccts_core u_ccts_core (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_instr_start(start),
    .i_instr_class(cls), .i_instr_bytes(nbytes), .o_instr_ready(ready), .o_instr_done(done),
    .o_mcycle_index(idx), .o_ale(ale), .o_mcycle_end(mend), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_t0_pin(pin), .i_t1_pin(pin),
    .i_int0_n(pin), .i_int1_n(pin), .i_tf0_ack(ack), .i_tf1_ack(ack), .o_tf0(tf0), .o_tf1(tf1),
    .o_timer_fast(fast));
  ccts_mem_model u_ccts_mem_model (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_ale(ale),
    .o_latch_count(ale_cnt));
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  function automatic bit mapped(input int a);
    return a >= 8'h80 && a <= 8'hA4 && !(a inside {8'h8F, 8'h94, 8'h9A});
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge i_core_clk);
    wr = 0;
    @(negedge i_core_clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd = 1;
    @(negedge i_core_clk);
    rd = 0;
    d = rdata;
    @(negedge i_core_clk);
  endtask
  task automatic run_instr(input ccts_class_t c, input int b, input bit sync);
    int n0, k, ex, mx;
    while (ready !== 1'b1 || (sync && mend !== 1'b1)) @(negedge i_core_clk);
    start = 1;
    cls = c;
    nbytes = b[2:0];
    @(posedge i_core_clk);
    #1 n0 = ale_cnt;
    @(negedge i_core_clk);
    start = 0;
    k = 0;
    mx = 0;
    while (done !== 1'b1 && k < 40) begin
      @(negedge i_core_clk);
      k++;
      if (idx > mx) mx = idx;
    end
    ex = c == CCTS_XMOVE ? XMOVE_MCYCLES : c == CCTS_DDMOVE ? DDMOVE_MCYCLES :
      c == CCTS_LONG ? MAX_MCYCLES : b < 1 ? MIN_MCYCLES : b > 5 ? MAX_MCYCLES : b;
    `CHK("mcycles", ex, ale_cnt - n0)
    `CHK("last index", ex - 1, mx)
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    int a, ex;
    void'($urandom(32'h009A));
    repeat (5) @(negedge i_core_clk);
    i_reset_n = 1;
    for (a = 0; a < 256; a++) begin
      mdl[a] = a inside {8'h80, 8'h90, 8'hA0, 8'hA1} ? RST_PORT : a == 8'h81 ? RST_STACK_POINTER : RST_ZERO;
    end
    for (a = 8'h7F; a <= 8'hA5; a++) begin
      rd_reg(a[7:0], v);
      `CHK("reset value", mapped(a) ? mdl[a] : 0, v)
    end
    for (a = 8'h7F; a <= 8'hA5; a++) begin
      if (!(a inside {8'h87, 8'h88, 8'h91, 8'h98, 8'hA4})) begin
        ex = $urandom_range(0, 255);
        wr_reg(a[7:0], ex[7:0]);
        if (mapped(a) && !(a inside {8'h96, 8'h97, 8'h9E, 8'h9F})) mdl[a] = ex;
      end
    end
    for (a = 8'h7F; a <= 8'hA5; a++) begin
      rd_reg(a[7:0], v);
      `CHK("readback", mapped(a) ? mdl[a] : 0, v)
    end
    `CHK("speed bits", 3'(mdl[8'h8E] >> 3), fast)
    for (a = 0; a < 4; a++) begin
      wr_reg(ADR_TIMER_MODE, 8'h01 << (4 * a[0]));
      wr_reg(ADR_CLOCK_CONTROL, a[1] ? 8'h08 << a[0] : 8'h00);
      wr_reg(ADR_TIMER0_COUNT_LOW + a[0], 8'h00);
      wr_reg(ADR_TIMER0_COUNT_HIGH + a[0], 8'h00);
      wr_reg(ADR_TIMER_CONTROL, 8'h10 << (2 * a[0]));
      repeat (600) @(negedge i_core_clk);
      wr_reg(ADR_TIMER_CONTROL, 8'h00);
      rd_reg(ADR_TIMER0_COUNT_LOW + a[0], v);
      ex = a[1] ? 150 : 50;
      `CHK("tick count in range", 1'b1, v >= ex - 1 && v <= ex + 1)
    end
    for (a = 0; a < 2; a++) begin
      wr_reg(ADR_TIMER_MODE, 8'h01 << (4 * a[0]));
      wr_reg(ADR_CLOCK_CONTROL, 8'h08 << a[0]);
      wr_reg(ADR_TIMER0_COUNT_LOW + a[0], 8'hFF);
      wr_reg(ADR_TIMER0_COUNT_HIGH + a[0], 8'hFF);
      wr_reg(ADR_TIMER_CONTROL, 8'h10 << (2 * a[0]));
      repeat (8) @(negedge i_core_clk);
      `CHK("overflow flag", 1'b1, a[0] ? tf1 : tf0)
      ack = 1;
      @(negedge i_core_clk);
      ack = 0;
      `CHK("flag after ack", 1'b0, a[0] ? tf1 : tf0)
      wr_reg(ADR_TIMER_CONTROL, 8'h00);
    end
    // Timer 0 as event counter on its pin
    wr_reg(ADR_TIMER_MODE, 8'h05);
    wr_reg(ADR_TIMER0_COUNT_LOW, 8'h00);
    wr_reg(ADR_TIMER_CONTROL, 8'h10);
    repeat (5) begin
      pin = 0;
      repeat (8) @(negedge i_core_clk);
      pin = 1;
      repeat (8) @(negedge i_core_clk);
    end
    wr_reg(ADR_TIMER_CONTROL, 8'h00);
    rd_reg(ADR_TIMER0_COUNT_LOW, v);
    `CHK("counted edges", 8'h05, v)
    // Second reset in mid-run
    i_reset_n = 0;
    repeat (2) @(negedge i_core_clk);
    i_reset_n = 1;
    `CHK("speed bits after reset", 3'h0, fast)
    `CHK("flag after reset", 1'b0, tf0)
    foreach (cq[i]) run_instr(cq[i], 1, 1);
    for (a = 0; a <= 6; a++) run_instr(CCTS_GENERIC, a, 1);
    for (a = 0; a < 12; a++) run_instr(ccts_class_t'($urandom_range(0, 3)), $urandom_range(0, 7), 0);
    report_and_stop;
  end
endmodule
bind ccts_core ccts_core_assertions #(.MCYCLE_CLOCKS(MCYCLE_CLOCKS), .LEGACY_CLOCKS(LEGACY_CLOCKS))
  u_ccts_core_assertions (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_instr_start(i_instr_start),
  .i_instr_class(i_instr_class), .i_instr_bytes(i_instr_bytes), .o_instr_ready(o_instr_ready),
  .o_instr_done(o_instr_done), .o_ale(o_ale), .o_mcycle_end(o_mcycle_end), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
  .o_timer_fast(o_timer_fast));
